/* File: logic/dsm_consts.svh */
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH

// register byte offsets on the module bus (16-bit words)
`define DSM_OFF_CONFIG   5'h00
`define DSM_OFF_IRQ      5'h04
`define DSM_OFF_PDATA    5'h14
`define DSM_OFF_PINCFG   5'h16

// module configuration word fields
`define DSM_CFG_STOP_BIT 15
`define DSM_CFG_FREEZE_HALT_BIT_BIT 14
`define DSM_CFG_FREEZE_SPARE_BIT_BIT 13
`define DSM_CFG_ARBITRATION_NUMBER_MSB 3
`define DSM_CFG_ARBITRATION_NUMBER_LSB 0

// interrupt word fields: high byte levels, low byte vector
`define DSM_IRQ_SYNC_MSB  13
`define DSM_IRQ_SYNC_LSB  11
`define DSM_IRQ_ASYNC_MSB 10
`define DSM_IRQ_ASYNC_LSB 8

// reset values
`define DSM_RST_STOP   1'b1
`define DSM_RST_ARBITRATION_NUMBER   4'h0
`define DSM_RST_LEVEL  3'h0
`define DSM_RST_VECTOR 8'h0F
`define DSM_RST_PIN    8'h00

// pin indices of the eight port pins
`define DSM_PIN_MISO 0
`define DSM_PIN_MOSI 1
`define DSM_PIN_SCK  2
`define DSM_PIN_SS   3
`define DSM_PIN_TXD  7

// serial contention: index of the first arbitration bit sent
`define DSM_ARB_LAST 2'd3

`endif

/* File: logic/dsm_pkg.sv */
package dsm_pkg;

  // interrupt arbitration states
  typedef enum logic [2:0] {
    DSM_ARB_IDLE    = 3'b001,
    DSM_ARB_CONTEND = 3'b010,
    DSM_ARB_VECTOR  = 3'b100
  } dsm_arb_state_type;

  // pin-side outputs of the synchronous serial engine
  typedef struct packed {
    logic       miso;
    logic       mosi;
    logic       sck;
    logic [3:0] pcs;
  } dsm_ser_out_type;

  // pin levels handed to the synchronous serial engine
  typedef struct packed {
    logic miso;
    logic mosi;
    logic sck;
    logic ss_n;
  } dsm_ser_in_type;

endpackage

/* File: logic/dsm_irq_arb.sv */
`timescale 1ns/100ps
`include "dsm_consts.svh"

module dsm_irq_arb
  import dsm_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // section requests and programming
  input  wire logic [2:0] sync_lvl,
  input  wire logic [2:0] async_lvl,
  input  wire logic       sync_req,
  input  wire logic       async_req,
  input  wire logic [7:1] vec_hi,
  input  wire logic [3:0] arbitration_number,
  // acknowledge cycle
  input  wire logic       iack,
  input  wire logic [2:0] mask,
  input  wire logic       arb_line_in,
  output logic      [7:1] irq_lines_r,
  output logic            arb_bit_r,
  output logic            arb_drive_r,
  output logic      [7:0] vec_data_r,
  output logic            vec_valid_r
);

  dsm_arb_state_type state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       src_r, src_nxt;
  logic       bit_nxt, drive_nxt, valid_nxt;
  logic [7:0] vec_nxt;

  // level to request line, zero level drives nothing
  function automatic logic [7:1] lvl_line(input logic [2:0] lvl);
    lvl_line = 7'h00;
    if (lvl != 3'h0) begin
      lvl_line[lvl] = 1'b1;
    end
  endfunction

  // active requests, tie at equal level goes to the sync section
  wire       sync_act  = sync_req & (sync_lvl != 3'h0);
  wire       async_act = async_req & (async_lvl != 3'h0);
  wire       pick_sync = sync_act & (!async_act | (sync_lvl >= async_lvl));
  wire [2:0] pend_lvl  = pick_sync ? sync_lvl : (async_act ? async_lvl : 3'h0);
  wire       qualify   = iack & (pend_lvl > mask) & (arbitration_number != 4'h0);
  wire       lost      = !arb_bit_r & arb_line_in;
  wire [7:1] lines_nxt = lvl_line(sync_act ? sync_lvl : 3'h0)
                       | lvl_line(async_act ? async_lvl : 3'h0);

  // contention sequence, msb of the arbitration number first
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    src_nxt   = src_r;
    bit_nxt   = arb_bit_r;
    drive_nxt = arb_drive_r;
    valid_nxt = 1'b0;
    vec_nxt   = vec_data_r;
    unique case (state_r)
      DSM_ARB_IDLE: begin
        if (qualify) begin
          state_nxt = DSM_ARB_CONTEND;
          cnt_nxt   = `DSM_ARB_LAST;
          src_nxt   = pick_sync;
          bit_nxt   = arbitration_number[`DSM_ARB_LAST];
          drive_nxt = 1'b1;
        end
      end
      DSM_ARB_CONTEND: begin
        if (lost) begin
          state_nxt = DSM_ARB_IDLE;
          bit_nxt   = 1'b0;
          drive_nxt = 1'b0;
        end else if (cnt_r == 2'd0) begin
          state_nxt = DSM_ARB_VECTOR;
          bit_nxt   = 1'b0;
          drive_nxt = 1'b0;
          valid_nxt = 1'b1;
          vec_nxt   = {vec_hi, src_r};
        end else begin
          cnt_nxt = cnt_r - 2'd1;
          bit_nxt = arbitration_number[cnt_r - 2'd1];
        end
      end
      DSM_ARB_VECTOR: begin
        state_nxt = DSM_ARB_IDLE;
      end
      default: begin
        state_nxt = DSM_ARB_IDLE;
      end
    endcase
  end

  // state and outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_r     <= DSM_ARB_IDLE;
      cnt_r       <= 2'd0;
      src_r       <= 1'b0;
      arb_bit_r   <= 1'b0;
      arb_drive_r <= 1'b0;
      vec_valid_r <= 1'b0;
      vec_data_r  <= 8'h00;
      irq_lines_r <= 7'h00;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      src_r       <= src_nxt;
      arb_bit_r   <= bit_nxt;
      arb_drive_r <= drive_nxt;
      vec_valid_r <= valid_nxt;
      vec_data_r  <= vec_nxt;
      irq_lines_r <= lines_nxt;
    end
  end

  // checks
  a_irq_level_map: assert property (@(posedge ref_clk) disable iff (!nrst)
    sync_req && sync_lvl != 3'h0 |=> irq_lines_r[$past(sync_lvl)])
    else $error("sync request line not asserted at its level");
  a_tie_sync_first: assert property (@(posedge ref_clk) disable iff (!nrst)
    qualify && state_r == DSM_ARB_IDLE && sync_act && async_act && sync_lvl == async_lvl
    |=> src_r)
    else $error("async section won a tie");
  a_no_contend: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == DSM_ARB_IDLE && iack && pend_lvl <= mask |=> !arb_drive_r)
    else $error("contended without a qualifying level");
  a_vector_win: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == DSM_ARB_IDLE && qualify ##1 (!lost) [*4] |=> vec_valid_r && vec_data_r[0] == src_r)
    else $error("vector not driven after a won contention");
  c_vector_out: cover property (@(posedge ref_clk) disable iff (!nrst) vec_valid_r);
  c_lost_arb: cover property (@(posedge ref_clk) disable iff (!nrst)
    state_r == DSM_ARB_CONTEND && lost);

endmodule

/* File: logic/dsm_global_ctrl.sv */
// Functional notes
// - stop bit gates module clock, config readable
// - writes to registers still valid during stop
// - stop set by write and by reset
// - freeze with halt bit halts at boundary
// - level field picks request line, zero disables
// - equal levels, sync section served first
// - contend only when level exceeds acknowledged mask
// - serial contention on nonzero arbitration number
// - vector upper bits from register, bit0 source
// - vector resets 0F, bit0 reads one
// - assignment bit picks serial or general pin
// - serial needs enable, slave data-out pin stays serial
// - direction bit zero input, one output
// - transmit enable forces transmit pin output
// - data writes drive outputs, reads show pins
// - data pin directions swap between master, slave
// - select0 direction picks fault input or output
// - selects one to three outputs only master
// - clock pin follows mode, ignores direction
// - unimplemented bits ignore writes, read zero
`timescale 1ns/100ps
`include "dsm_consts.svh"

module dsm_global_ctrl
  import dsm_pkg::*;
(
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  // module bus register port
  input  wire logic [4:0]      bus_addr,
  input  wire logic            bus_wr,
  input  wire logic            bus_rd,
  input  wire logic [1:0]      bus_be,
  input  wire logic [15:0]     bus_wdata,
  output logic      [15:0]     bus_rdata_r,
  // module bus freeze and interrupt acknowledge
  input  wire logic            freeze,
  input  wire logic            iack,
  input  wire logic [2:0]      priority_mask,
  input  wire logic            arb_line_in,
  output logic                 arb_bit_r,
  output logic                 arb_drive_r,
  output logic      [7:1]      irq_lines_r,
  output logic      [7:0]      vec_data_r,
  output logic                 vec_valid_r,
  // serial engines
  input  wire logic            sync_irq_req,
  input  wire logic            async_irq_req,
  input  wire logic            master_mode,
  input  wire logic            sync_serial_enable,
  input  wire logic            tx_enable,
  input  wire logic            tx_data,
  input  wire dsm_ser_out_type ser_out,
  output dsm_ser_in_type       ser_in_r,
  output logic                 mode_fault_r,
  output logic                 clk_run_r,
  output logic                 halt_req_r,
  output logic                 queue_rd_ok_r,
  // port pins
  input  wire logic [7:0]      pin_in,
  output logic      [7:0]      pin_out_r,
  output logic      [7:0]      pin_oe_r
);

  // register state
  logic       stop_r, stop_nxt;
  logic       freeze_halt_bit_r, freeze_halt_bit_nxt;
  logic       freeze_spare_bit_r, freeze_spare_bit_nxt;
  logic [3:0] arbitration_number_r, arbitration_number_nxt;
  logic [2:0] sync_lvl_r, sync_lvl_nxt;
  logic [2:0] async_lvl_r, async_lvl_nxt;
  logic [7:1] vec_r, vec_nxt;
  logic [7:0] pin_assign_r, pin_assign_nxt;
  logic [7:0] pin_dir_r, pin_dir_nxt;
  logic [7:0] port_data_r, port_data_nxt;
  logic [15:0] rdata_nxt;
  logic [7:0]  pout_nxt;
  logic [7:0]  poe_nxt;
  logic [6:0]  own;
  dsm_ser_in_type ser_in_nxt;

  // word decode on address bits 4..1
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] off);
    addr_hit = (addr[4:1] == off[4:1]);
  endfunction

  // select a written byte lane or keep the old byte
  function automatic logic [7:0] lane(input logic we, input logic [7:0] wd,
                                      input logic [7:0] old);
    lane = we ? wd : old;
  endfunction

  // address decode and byte strobes
  wire sel_cfg    = addr_hit(bus_addr, `DSM_OFF_CONFIG);
  wire sel_irq    = addr_hit(bus_addr, `DSM_OFF_IRQ);
  wire sel_pdata  = addr_hit(bus_addr, `DSM_OFF_PDATA);
  wire sel_pincfg = addr_hit(bus_addr, `DSM_OFF_PINCFG);
  wire cfg_hi_we  = bus_wr & sel_cfg & bus_be[1];
  wire cfg_lo_we  = bus_wr & sel_cfg & bus_be[0];
  wire irq_hi_we  = bus_wr & sel_irq & bus_be[1];
  wire irq_lo_we  = bus_wr & sel_irq & bus_be[0];
  wire pd_lo_we   = bus_wr & sel_pdata & bus_be[0];
  wire pc_hi_we   = bus_wr & sel_pincfg & bus_be[1];
  wire pc_lo_we   = bus_wr & sel_pincfg & bus_be[0];

  // register next values; writes land whatever the stop state
  assign stop_nxt       = cfg_hi_we ? bus_wdata[`DSM_CFG_STOP_BIT] : stop_r;
  assign freeze_halt_bit_nxt       = cfg_hi_we ? bus_wdata[`DSM_CFG_FREEZE_HALT_BIT_BIT] : freeze_halt_bit_r;
  assign freeze_spare_bit_nxt       = cfg_hi_we ? bus_wdata[`DSM_CFG_FREEZE_SPARE_BIT_BIT] : freeze_spare_bit_r;
  assign arbitration_number_nxt       = cfg_lo_we ? bus_wdata[`DSM_CFG_ARBITRATION_NUMBER_MSB:`DSM_CFG_ARBITRATION_NUMBER_LSB] : arbitration_number_r;
  assign sync_lvl_nxt   = irq_hi_we ? bus_wdata[`DSM_IRQ_SYNC_MSB:`DSM_IRQ_SYNC_LSB]
                                    : sync_lvl_r;
  assign async_lvl_nxt  = irq_hi_we ? bus_wdata[`DSM_IRQ_ASYNC_MSB:`DSM_IRQ_ASYNC_LSB]
                                    : async_lvl_r;
  assign vec_nxt        = irq_lo_we ? bus_wdata[7:1] : vec_r;
  assign port_data_nxt  = lane(pd_lo_we, bus_wdata[7:0], port_data_r);
  assign pin_assign_nxt = lane(pc_hi_we, bus_wdata[15:8], pin_assign_r);
  assign pin_dir_nxt    = lane(pc_lo_we, bus_wdata[7:0], pin_dir_r);

  // read data; unused bits and unmapped words read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (sel_cfg) begin
      rdata_nxt[`DSM_CFG_STOP_BIT] = stop_r;
      rdata_nxt[`DSM_CFG_FREEZE_HALT_BIT_BIT] = freeze_halt_bit_r;
      rdata_nxt[`DSM_CFG_FREEZE_SPARE_BIT_BIT] = freeze_spare_bit_r;
      rdata_nxt[`DSM_CFG_ARBITRATION_NUMBER_MSB:`DSM_CFG_ARBITRATION_NUMBER_LSB] = arbitration_number_r;
    end else if (sel_irq) begin
      rdata_nxt[`DSM_IRQ_SYNC_MSB:`DSM_IRQ_SYNC_LSB]   = sync_lvl_r;
      rdata_nxt[`DSM_IRQ_ASYNC_MSB:`DSM_IRQ_ASYNC_LSB] = async_lvl_r;
      rdata_nxt[7:0] = {vec_r, 1'b1};
    end else if (sel_pdata) begin
      rdata_nxt[7:0] = pin_in;
    end else if (sel_pincfg) begin
      rdata_nxt = {pin_assign_r, pin_dir_r};
    end
  end

  // serial ownership of pins 0..6; slave keeps the data-out pin regardless
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      own[i] = pin_assign_r[i] & sync_serial_enable;
    end
    if (!master_mode) begin
      own[`DSM_PIN_MISO] = pin_assign_r[`DSM_PIN_MISO];
    end
  end

  // pin drive: general pins follow direction, serial pins follow mode
  always_comb begin
    pout_nxt = port_data_r;
    poe_nxt  = pin_dir_r;
    if (own[`DSM_PIN_MISO]) begin
      pout_nxt[0] = ser_out.miso;
      poe_nxt[0]  = !master_mode & pin_dir_r[0];
    end
    if (own[`DSM_PIN_MOSI]) begin
      pout_nxt[1] = ser_out.mosi;
      poe_nxt[1]  = master_mode & pin_dir_r[1];
    end
    if (own[`DSM_PIN_SCK]) begin
      pout_nxt[2] = ser_out.sck;
      poe_nxt[2]  = master_mode;
    end
    if (own[`DSM_PIN_SS]) begin
      pout_nxt[3] = ser_out.pcs[0];
      poe_nxt[3]  = master_mode & pin_dir_r[3];
    end
    for (int i = 4; i < 7; i++) begin
      if (own[i]) begin
        pout_nxt[i] = ser_out.pcs[i - 3];
        poe_nxt[i]  = master_mode & pin_dir_r[i];
      end
    end
    if (tx_enable) begin
      pout_nxt[`DSM_PIN_TXD] = tx_data;
      poe_nxt[`DSM_PIN_TXD]  = 1'b1;
    end
  end

  // inputs handed to the serial engine; disabled inputs read idle
  always_comb begin
    ser_in_nxt.miso = (master_mode & own[0] & !pin_dir_r[0]) ? pin_in[0] : 1'b0;
    ser_in_nxt.mosi = (!master_mode & own[1] & !pin_dir_r[1]) ? pin_in[1] : 1'b0;
    ser_in_nxt.sck  = (!master_mode & own[2]) ? pin_in[2] : 1'b0;
    ser_in_nxt.ss_n = (!master_mode & own[3] & !pin_dir_r[3]) ? pin_in[3] : 1'b1;
  end

  // an asserted low select input in master mode is a mode fault
  wire fault_nxt = master_mode & own[3] & !pin_dir_r[3] & !pin_in[3];

  // freeze halts the engine only with the halt bit; spare bit unused
  wire halt_nxt = freeze & freeze_halt_bit_r;

  // register file
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      stop_r       <= `DSM_RST_STOP;
      freeze_halt_bit_r       <= 1'b0;
      freeze_spare_bit_r       <= 1'b0;
      arbitration_number_r       <= `DSM_RST_ARBITRATION_NUMBER;
      sync_lvl_r   <= `DSM_RST_LEVEL;
      async_lvl_r  <= `DSM_RST_LEVEL;
      vec_r        <= 7'(`DSM_RST_VECTOR >> 1);
      port_data_r  <= `DSM_RST_PIN;
      pin_assign_r <= `DSM_RST_PIN;
      pin_dir_r    <= `DSM_RST_PIN;
    end else begin
      stop_r       <= stop_nxt;
      freeze_halt_bit_r       <= freeze_halt_bit_nxt;
      freeze_spare_bit_r       <= freeze_spare_bit_nxt;
      arbitration_number_r       <= arbitration_number_nxt;
      sync_lvl_r   <= sync_lvl_nxt;
      async_lvl_r  <= async_lvl_nxt;
      vec_r        <= vec_nxt;
      port_data_r  <= port_data_nxt;
      pin_assign_r <= pin_assign_nxt;
      pin_dir_r    <= pin_dir_nxt;
    end
  end

  // bus read data and engine control outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bus_rdata_r   <= 16'h0000;
      clk_run_r     <= 1'b0;
      queue_rd_ok_r <= 1'b0;
      halt_req_r    <= 1'b0;
    end else begin
      bus_rdata_r   <= bus_rd ? rdata_nxt : 16'h0000;
      clk_run_r     <= !stop_r;
      queue_rd_ok_r <= !stop_r;
      halt_req_r    <= halt_nxt;
    end
  end

  // pin and serial-input outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pin_out_r    <= 8'h00;
      pin_oe_r     <= 8'h00;
      ser_in_r     <= 4'h1;
      mode_fault_r <= 1'b0;
    end else begin
      pin_out_r    <= pout_nxt;
      pin_oe_r     <= poe_nxt;
      ser_in_r     <= ser_in_nxt;
      mode_fault_r <= fault_nxt;
    end
  end

  // interrupt levels, arbitration and vector
  dsm_irq_arb u_arb (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .sync_lvl    (sync_lvl_r),
    .async_lvl   (async_lvl_r),
    .sync_req    (sync_irq_req),
    .async_req   (async_irq_req),
    .vec_hi      (vec_r),
    .arbitration_number        (arbitration_number_r),
    .iack        (iack),
    .mask        (priority_mask),
    .arb_line_in (arb_line_in),
    .irq_lines_r (irq_lines_r),
    .arb_bit_r   (arb_bit_r),
    .arb_drive_r (arb_drive_r),
    .vec_data_r  (vec_data_r),
    .vec_valid_r (vec_valid_r)
  );

  // checks
  a_stop_after_reset: assert property (@(posedge ref_clk)
    $rose(nrst) ##1 !bus_wr |-> !clk_run_r)
    else $error("module not in stop after reset");
  a_stop_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    cfg_hi_we && bus_wdata[`DSM_CFG_STOP_BIT] |-> ##2 !clk_run_r && !queue_rd_ok_r)
    else $error("clock not gated after stop write");
  a_write_in_stop: assert property (@(posedge ref_clk) disable iff (!nrst)
    stop_r && irq_lo_we |=> vec_r == $past(bus_wdata[7:1]))
    else $error("vector write lost during stop");
  a_freeze_halt: assert property (@(posedge ref_clk) disable iff (!nrst)
    freeze && freeze_halt_bit_r |=> halt_req_r)
    else $error("freeze with halt bit did not request halt");
  a_freeze_spare: assert property (@(posedge ref_clk) disable iff (!nrst)
    !freeze_halt_bit_r |=> !halt_req_r)
    else $error("halt requested without halt bit");
  a_vec_bit0: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus_rd && sel_irq |=> bus_rdata_r[0])
    else $error("vector bit0 read as zero");
  a_unused_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus_rd && sel_cfg |=> bus_rdata_r[12:4] == 9'h000)
    else $error("unimplemented config bits read nonzero");
  a_txd_force: assert property (@(posedge ref_clk) disable iff (!nrst)
    tx_enable |=> pin_oe_r[`DSM_PIN_TXD] && pin_out_r[`DSM_PIN_TXD] == $past(tx_data))
    else $error("transmit pin not forced to output");
  a_sck_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
    own[`DSM_PIN_SCK] |=> pin_oe_r[`DSM_PIN_SCK] == $past(master_mode))
    else $error("clock pin direction does not follow mode");
  a_pin_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus_rd && sel_pdata |=> bus_rdata_r[7:0] == $past(pin_in))
    else $error("port data read does not show pins");
  a_gpio_dir: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pin_assign_r[1] |=> pin_oe_r[1] == $past(pin_dir_r[1]))
    else $error("general pin direction wrong");
  // pin ownership, select roles and request release
  a_assign_gpio: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pin_assign_r[4] |=> pin_out_r[4] == $past(port_data_r[4]))
    else $error("general pin not driven from port data");
  a_master_enable: assert property (@(posedge ref_clk) disable iff (!nrst)
    master_mode && !sync_serial_enable |=> pin_out_r[1] == $past(port_data_r[1]))
    else $error("serial took a pin without enable in master mode");
  a_slave_miso: assert property (@(posedge ref_clk) disable iff (!nrst)
    !master_mode && pin_assign_r[0] && pin_dir_r[0]
    |=> pin_oe_r[0] && pin_out_r[0] == $past(ser_out.miso))
    else $error("slave data-out pin not driven by serial");
  a_select_fault: assert property (@(posedge ref_clk) disable iff (!nrst)
    master_mode && own[3] && !pin_dir_r[3] && !pin_in[3] |=> mode_fault_r)
    else $error("asserted select input gave no mode fault");
  a_slave_selects: assert property (@(posedge ref_clk) disable iff (!nrst)
    !master_mode && own[4] |=> !pin_oe_r[4])
    else $error("select output driven in slave mode");
  a_irq_release: assert property (@(posedge ref_clk) disable iff (!nrst)
    !sync_irq_req && !async_irq_req |=> irq_lines_r == 7'h00)
    else $error("request line held without a request");
  a_stop_reads: assert property (@(posedge ref_clk) disable iff (!nrst)
    stop_r && bus_rd && sel_cfg |=> bus_rdata_r[`DSM_CFG_STOP_BIT])
    else $error("config word not readable in stop");
  a_unused_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus_rd && sel_irq |=> bus_rdata_r[15:14] == 2'b00)
    else $error("unimplemented interrupt bits read nonzero");
  a_dir_input: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pin_assign_r[5] && !pin_dir_r[5] |=> !pin_oe_r[5])
    else $error("input pin driven");
  c_stop_exit: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(clk_run_r));
  c_mode_fault: cover property (@(posedge ref_clk) disable iff (!nrst) mode_fault_r);
  c_slave_miso: cover property (@(posedge ref_clk) disable iff (!nrst)
    !master_mode && own[0] && pin_oe_r[0]);

endmodule

/* File: testbench/dsm_host_model.sv */
`timescale 1ns/100ps

module dsm_host_model (
  // clock
  input  wire logic        ref_clk,
  // register bus
  output logic      [4:0]  bus_addr,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic      [1:0]  bus_be,
  output logic      [15:0] bus_wdata,
  input  wire logic [15:0] bus_rdata_r,
  // acknowledge cycle
  output logic             iack,
  output logic      [2:0]  priority_mask,
  output logic             arb_line_in,
  input  wire logic        arb_bit_r,
  input  wire logic        arb_drive_r,
  input  wire logic [7:0]  vec_data_r,
  input  wire logic        vec_valid_r
);
  logic rival_bit;

  // wired-or contention line shared with one rival module
  assign arb_line_in = (arb_drive_r & arb_bit_r) | rival_bit;

  // idle bus at time zero
  initial begin
    {bus_addr, bus_wr, bus_rd, bus_be, bus_wdata} = 25'h0;
    {iack, priority_mask, rival_bit} = 5'h00;
  end

  // one write cycle, strobe held over one sampling edge
  task automatic wr(input logic [4:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge ref_clk);
    bus_addr = a;
    bus_be = be;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge ref_clk);
    bus_wr = 1'b0;
    bus_wdata = ~d;
  endtask

  // one read cycle, data taken the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge ref_clk);
    bus_rd = 1'b0;
    d = bus_rdata_r;
  endtask

  // acknowledge at a mask; the rival sends its number msb first
  task automatic ack(input logic [2:0] m, input logic [3:0] rival, output logic won,
                     output logic [7:0] v);
    won = 1'b0;
    v = 8'h00;
    @(negedge ref_clk);
    iack = 1'b1;
    priority_mask = m;
    for (int i = 3; i >= -3; i--) begin
      @(negedge ref_clk);
      iack = 1'b0;
      priority_mask = ~m;
      rival_bit = (i >= 0) ? rival[i] : 1'b0;
      if (vec_valid_r === 1'b1) begin
        won = 1'b1;
        v = vec_data_r;
      end
    end
  endtask
endmodule

/* File: testbench/dsm_global_ctrl_bench.sv */
`timescale 1ns/100ps
`define CHK(what, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("ERROR %s expected %h seen %h", what, e, g); \
  end \
end

module dsm_global_ctrl_bench
  import dsm_pkg::*;
;
  logic ref_clk, nrst, freeze, sync_irq_req, async_irq_req, master_mode, sync_serial_enable;
  logic tx_enable, tx_data, iack, arb_line_in, bus_wr, bus_rd, arb_bit_r, arb_drive_r;
  logic vec_valid_r, mode_fault_r, clk_run_r, halt_req_r, queue_rd_ok_r, won;
  logic [1:0]      bus_be;
  logic [2:0]      priority_mask;
  logic [3:0]      arbitration_number;
  logic [4:0]      bus_addr;
  logic [7:1]      irq_lines_r;
  logic [7:0]      vec_data_r, pin_in, pin_out_r, pin_oe_r, vec, pd, got_v;
  logic [15:0]     bus_wdata, bus_rdata_r, rd_d;
  dsm_ser_out_type ser_out;
  dsm_ser_in_type  ser_in_r;
  int              seed, n_fail, n_compared;
  // acknowledge cases: sync level, async level, mask, rival, {win, sync bit}
  logic [2:0] c_s [4] = '{3'd5, 3'd5, 3'd0, 3'd6};
  logic [2:0] c_a [4] = '{3'd5, 3'd5, 3'd3, 3'd0};
  logic [2:0] c_m [4] = '{3'd4, 3'd5, 3'd2, 3'd0};
  logic [3:0] c_r [4] = '{4'h0, 4'h0, 4'h0, 4'hF};
  logic [1:0] c_w [4] = '{2'b11, 2'b00, 2'b10, 2'b00};

  dsm_global_ctrl uut (.*);
  dsm_host_model host (.*);

  // one request line per nonzero level
  function automatic logic [7:1] exp_lines(input logic [2:0] l);
    exp_lines = (l == 3'd0) ? 7'h00 : 7'(7'h01 << (l - 3'd1));
  endfunction

  // shared upper vector bits, low bit names the section
  function automatic logic [7:0] exp_vec(input logic [7:0] v, input logic sync);
    exp_vec = {v[7:1], sync};
  endfunction

  // set pin configuration and modes, let registered pins settle
  task automatic pins(input logic [7:0] asg, dir, input logic mm, se, te);
    host.wr(5'h16, 2'b11, {asg, dir});
    master_mode = mm;
    sync_serial_enable = se;
    tx_enable = te;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // watchdog
  initial begin
    #50000;
    n_fail++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    seed = 48;
    n_fail = 0;
    n_compared = 0;
    nrst = 1'b0;
    {freeze, sync_irq_req, async_irq_req, master_mode, sync_serial_enable} = 5'h00;
    {tx_enable, tx_data} = 2'h0;
    pin_in = 8'h00;
    ser_out = 7'h00;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    `CHK("clk_run_r", 1'b0, clk_run_r)
    `CHK("queue_rd_ok_r", 1'b0, queue_rd_ok_r)
    host.rd(5'h00, rd_d);
    `CHK("config", 16'h8000, rd_d)
    host.rd(5'h04, rd_d);
    `CHK("irq word", 16'h000F, rd_d)
    host.rd(5'h16, rd_d);
    `CHK("pin config", 16'h0000, rd_d)
    host.rd(5'h0A, rd_d);
    `CHK("unmapped", 16'h0000, rd_d)
    // writes while still stopped, unimplemented bits set
    vec = 8'($random(seed));
    host.wr(5'h04, 2'b11, {2'b11, 3'd5, 3'd5, vec});
    host.rd(5'h04, rd_d);
    `CHK("irq word", {2'b00, 3'd5, 3'd5, exp_vec(vec, 1'b1)}, rd_d)
    // nonzero arbitration number, leave stop
    arbitration_number = 4'(1 + {$random(seed)} % 14);
    host.wr(5'h00, 2'b11, {3'b010, 9'h1FF, arbitration_number});
    repeat (2) @(negedge ref_clk);
    host.rd(5'h00, rd_d);
    `CHK("config", {3'b010, 9'h000, arbitration_number}, rd_d)
    `CHK("clk_run_r", 1'b1, clk_run_r)
    `CHK("queue_rd_ok_r", 1'b1, queue_rd_ok_r)
    freeze = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK("halt_req_r", 1'b1, halt_req_r)
    host.wr(5'h00, 2'b11, {3'b001, 9'h000, arbitration_number});
    repeat (2) @(negedge ref_clk);
    `CHK("halt_req_r", 1'b0, halt_req_r)
    freeze = 1'b0;
    // every level, high byte only so the vector stays
    for (int l = 0; l < 8; l++) begin
      host.wr(5'h04, 2'b10, {2'b00, 3'(l), 3'd0, 8'h00});
      sync_irq_req = 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK("irq_lines_r", exp_lines(3'(l)), irq_lines_r)
      sync_irq_req = 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK("irq_lines_r", 7'h00, irq_lines_r)
    end
    // acknowledge cases with both sections requesting
    {sync_irq_req, async_irq_req} = 2'b11;
    for (int k = 0; k < 4; k++) begin
      host.wr(5'h04, 2'b10, {2'b00, c_s[k], c_a[k], 8'h00});
      repeat (2) @(negedge ref_clk);
      host.ack(c_m[k], c_r[k], won, got_v);
      `CHK("won", c_w[k][1], won)
      if (c_w[k][1]) `CHK("vector", exp_vec(vec, c_w[k][0]), got_v)
    end
    // pin scenarios
    {sync_irq_req, async_irq_req} = 2'b00;
    pd = 8'($random(seed));
    pin_in = 8'($random(seed));
    ser_out = 7'($random(seed));
    tx_data = 1'b1;
    host.wr(5'h14, 2'b01, {8'h00, pd});
    pins(8'h00, 8'hFF, 1'b1, 1'b1, 1'b0);
    `CHK("pin_oe_r", 8'hFF, pin_oe_r)
    `CHK("pin_out_r", pd, pin_out_r)
    host.rd(5'h14, rd_d);
    `CHK("port data", {8'h00, pin_in}, rd_d)
    pins(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
    `CHK("pin_oe_r", 8'h80, pin_oe_r)
    `CHK("tx pin", tx_data, pin_out_r[7])
    pins(8'h7F, 8'h0A, 1'b1, 1'b1, 1'b0);
    `CHK("pin_oe_r", 8'h0E, pin_oe_r)
    `CHK("data out", ser_out.mosi, pin_out_r[1])
    `CHK("data in", pin_in[0], ser_in_r.miso)
    pins(8'h7F, 8'hFF, 1'b1, 1'b0, 1'b0);
    `CHK("pin_out_r", pd, pin_out_r)
    pins(8'h7F, 8'h7F, 1'b0, 1'b1, 1'b0);
    `CHK("pin_oe_r", 8'h01, pin_oe_r)
    `CHK("ser_in_r", {2'b00, pin_in[2], 1'b1}, ser_in_r)
    pins(8'h01, 8'h01, 1'b0, 1'b0, 1'b0);
    `CHK("slave out", ser_out.miso, pin_out_r[0])
    pin_in[3] = 1'b0;
    pins(8'h7F, 8'h00, 1'b1, 1'b1, 1'b0);
    `CHK("mode_fault_r", 1'b1, mode_fault_r)
    // back into stop by a write, registers still writable
    host.wr(5'h00, 2'b11, {3'b100, 9'h000, arbitration_number});
    repeat (2) @(negedge ref_clk);
    `CHK("clk_run_r", 1'b0, clk_run_r)
    host.wr(5'h16, 2'b11, 16'hA55A);
    host.rd(5'h16, rd_d);
    `CHK("pin config", 16'hA55A, rd_d)
    tally_and_finish();
  end
endmodule
